// ===== rtl/periph_disable_regs.vh
// Constants for the peripheral disable register bank.
// Assumes a byte-wide register file reached over a 32-bit Avalon-MM slave port.
`ifndef PERIPH_DISABLE_REGS_VH
`define PERIPH_DISABLE_REGS_VH

// Register indices; the byte address is four times the index
`define IDX_DISABLE_SYS         12'h060
`define IDX_DISABLE_TIMERS      12'h061
`define IDX_DISABLE_ANALOG      12'h063
`define IDX_DISABLE_WAVEFORM    12'h064
`define IDX_DISABLE_PWM_CAPTURE 12'h065
`define IDX_DISABLE_SERIAL      12'h066

// Number of disable registers and of peripheral lines
`define NUM_DISABLE_REGS        6
`define NUM_PERIPH              43

// Implemented-bit masks; unimplemented bits read zero and ignore writes
`define MASK_SYS                8'hFB
`define MASK_TIMERS             8'hFF
`define MASK_ANALOG             8'hE7
`define MASK_WAVEFORM           8'h7F
`define MASK_PWM_CAPTURE        8'h77
`define MASK_SERIAL             8'hFF

// Reset value of every disable register
`define DISABLE_RESET           8'h00

// Field positions
`define BIT_SYSCLK_GATE         7
`define BIT_ZERO_CROSS          0

// Cycles a peripheral stays blocked from the bus after re-enable
`define REENABLE_HOLD_CYCLES    2

`endif

// ===== rtl/disable_reg_cell.v
// One byte-wide disable register with its own implemented-bit mask.
// Assumes the parent decodes the address and supplies a one-cycle write strobe.
`timescale 1ns/1ps

module disable_reg_cell #(
	parameter [7:0] MASK = 8'hFF
) (
	input  wire       clk,
	input  wire       nrst,
	input  wire       wr_en,
	input  wire [7:0] wr_data,
	output reg  [7:0] value_q
);

	// Register with asynchronous clear; masked bits stay zero
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			value_q <= 8'h00;
		end else if (wr_en) begin
			value_q <= wr_data & MASK;
		end
	end

endmodule

// ===== rtl/peripheral_module_disable.v
// Peripheral disable register bank behind an Avalon-MM slave port.
// Assumes the peripherals take a synchronous reset-hold, a clock-gate enable
// and a bus-select mask from this block, and that all share CLK.
// Operation
// [RULE1] Every disable bit clears on system reset, so all peripherals start on
// [RULE2] Writing 1 disables that bit's peripheral, writing 0 enables it
// [RULE3] A disabled peripheral is held in reset continuously
// [RULE4] Disabled peripheral registers ignore writes and read as zero
// [RULE5] A disabled peripheral has all outputs forced inactive
// [RULE6] Re-enabled peripheral resumes with its power-on register values
// [RULE7] Master waits two instruction cycles before touching a re-enabled peripheral
// [RULE8] Bit 7 of the system register gates system clock off the peripherals
// [RULE9] Quarter-rate clocked peripherals keep their clock despite the gate bit
// [RULE10] System register layout: clock gate, vref, detector, checksum, scanner, clkref, ioc
// [RULE11] Timer register: measurement timer bit 7, timers 0 to 6 below
// [RULE12] Analog register: tuning, DAC, ADC, comparators 2 and 1, zero-cross
// [RULE13] Zero-cross disable acts only as the configuration fuse allows
// [RULE14] Waveform register: generators 3..1, modulator, oscillators 3..1; bit 7 unused
// [RULE15] PWM register: PWM 3..1 in bits 6..4, capture 3..1 in bits 2..0
// [RULE16] Serial register: UARTs 5..1, SPI 2 and 1, I2C in bit 0
// [RULE17] Each bit drives reset-hold, clock-gate and register-select masks
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "periph_disable_regs.vh"

module peripheral_module_disable (
	input  wire        CLK,
	input  wire        NRST,
	input  wire [13:0] AVS_ADDRESS,
	input  wire        AVS_READ,
	input  wire        AVS_WRITE,
	input  wire [31:0] AVS_WRITEDATA,
	input  wire [3:0]  AVS_BYTEENABLE,
	output reg  [31:0] AVS_READDATA,
	output wire        AVS_WAITREQUEST,
	output wire [1:0]  AVS_RESPONSE,
	input  wire        ZERO_CROSS_FUSE_ALLOW,
	input  wire        OSC_CLK_EN,
	output wire        PERIPH_SYSCLK_EN,
	output wire        QUARTER_CLK_EN,
	output wire [42:0] PERIPH_RESET_HOLD,
	output wire [42:0] PERIPH_CLK_EN,
	output wire [42:0] PERIPH_OUT_EN,
	output wire [42:0] PERIPH_REG_SEL
);

	// Register word index and decode of the six disable registers
	wire [11:0] word_idx;
	wire [5:0]  reg_hit;
	wire        any_hit;

	assign word_idx = AVS_ADDRESS[13:2];
	assign reg_hit[0] = (word_idx == `IDX_DISABLE_SYS);
	assign reg_hit[1] = (word_idx == `IDX_DISABLE_TIMERS);
	assign reg_hit[2] = (word_idx == `IDX_DISABLE_ANALOG);
	assign reg_hit[3] = (word_idx == `IDX_DISABLE_WAVEFORM);
	assign reg_hit[4] = (word_idx == `IDX_DISABLE_PWM_CAPTURE);
	assign reg_hit[5] = (word_idx == `IDX_DISABLE_SERIAL);
	assign any_hit = |reg_hit;

	// Bus handshake: idle, then a single answer cycle per request
	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_ACK  = 2'b10;

	reg  [1:0] state_q;
	reg  [1:0] state_d;
	wire       req;
	wire       ack;

	assign req = AVS_READ | AVS_WRITE;
	assign ack = state_q[1];

	// Waitrequest stays high until the answer cycle
	assign AVS_WAITREQUEST = req & ~ack;
	// Unmapped addresses answer with a slave error
	assign AVS_RESPONSE = (ack && !any_hit) ? 2'b10 : 2'b00;

	// Next-state logic for the handshake
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (req) begin
					state_d = ST_ACK;
				end
			end
			ST_ACK: begin
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// Handshake state register
	always @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Write strobe fires once, at the edge the master sees waitrequest low
	wire       wr_fire;
	wire [5:0] wr_en;
	wire [7:0] reg_val [0:5];

	assign wr_fire = ack & AVS_WRITE & AVS_BYTEENABLE[0];

	// [RULE10] System register bits
	// [RULE11] Timer register bits
	// [RULE12] Analog register bits
	// [RULE14] Waveform register bits
	// [RULE15] PWM and capture bits
	// [RULE16] Serial register bits
	localparam [47:0] MASKS = {`MASK_SERIAL, `MASK_PWM_CAPTURE, `MASK_WAVEFORM,
	                           `MASK_ANALOG, `MASK_TIMERS, `MASK_SYS};

	genvar gi;
	generate
		for (gi = 0; gi < `NUM_DISABLE_REGS; gi = gi + 1) begin : g_reg
			assign wr_en[gi] = wr_fire & reg_hit[gi];
			// [RULE1] Reset to zero
			// [RULE2] Write sets disables
			disable_reg_cell #(
				.MASK (MASKS[gi*8 +: 8])
			) u_cell (
				.clk     (CLK),
				.nrst    (NRST),
				.wr_en   (wr_en[gi]),
				.wr_data (AVS_WRITEDATA[7:0]),
				.value_q (reg_val[gi])
			);
		end
	endgenerate

	// Read data is registered when the read is taken in idle, ready for the answer cycle; other bits read zero
	reg [7:0] rd_byte;

	always @* begin
		rd_byte = 8'h00;
		case (word_idx)
			`IDX_DISABLE_SYS:         rd_byte = reg_val[0];
			`IDX_DISABLE_TIMERS:      rd_byte = reg_val[1];
			`IDX_DISABLE_ANALOG:      rd_byte = reg_val[2];
			`IDX_DISABLE_WAVEFORM:    rd_byte = reg_val[3];
			`IDX_DISABLE_PWM_CAPTURE: rd_byte = reg_val[4];
			`IDX_DISABLE_SERIAL:      rd_byte = reg_val[5];
			default:                  rd_byte = 8'h00;
		endcase
	end

	// Read data flop, loaded when a read is accepted
	always @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			AVS_READDATA <= 32'h00000000;
		end else if (state_q[0] && AVS_READ) begin
			AVS_READDATA <= {24'h000000, rd_byte};
		end
	end

	// Register values by name, so the field taps below read plainly
	wire [7:0] sys_value;
	wire [7:0] timers_value;
	wire [7:0] analog_value;
	wire [7:0] waveform_value;
	wire [7:0] pwm_capture_value;
	wire [7:0] serial_value;

	assign sys_value         = reg_val[0];
	assign timers_value      = reg_val[1];
	assign analog_value      = reg_val[2];
	assign waveform_value    = reg_val[3];
	assign pwm_capture_value = reg_val[4];
	assign serial_value      = reg_val[5];

	// System register: clock gate on top, bit 2 has no peripheral behind it
	wire periph_sysclk_gate;
	wire vref_disable;
	wire voltage_detect_disable;
	wire checksum_unit_disable;
	wire memory_scanner_disable;
	wire clock_ref_out_disable;
	wire pin_change_irq_disable;

	assign periph_sysclk_gate     = sys_value[`BIT_SYSCLK_GATE];
	assign vref_disable           = sys_value[6];
	assign voltage_detect_disable = sys_value[5];
	assign checksum_unit_disable  = sys_value[4];
	assign memory_scanner_disable = sys_value[3];
	assign clock_ref_out_disable  = sys_value[1];
	assign pin_change_irq_disable = sys_value[0];

	// Timer register: measurement timer on top, general timers 6..0 below
	wire       signal_meas_timer_disable;
	wire [6:0] timer_n_disable;

	assign signal_meas_timer_disable = timers_value[7];
	assign timer_n_disable           = timers_value[6:0];

	// Analog register: bits 4 and 3 have no peripheral behind them
	wire active_tuning_disable;
	wire dac_unit_disable;
	wire adc_unit_disable;
	wire comparator_two_disable;
	wire comparator_one_disable;
	wire zero_cross_disable;

	assign active_tuning_disable  = analog_value[7];
	assign dac_unit_disable       = analog_value[6];
	assign adc_unit_disable       = analog_value[5];
	assign comparator_two_disable = analog_value[2];
	assign comparator_one_disable = analog_value[1];
	// [RULE13] Fuse qualifies zero-cross
	// The bit still reads back as written; only its effect is gated
	assign zero_cross_disable     = analog_value[`BIT_ZERO_CROSS] & ZERO_CROSS_FUSE_ALLOW;

	// Waveform register: bit 7 has no peripheral behind it
	wire waveform_gen3_disable;
	wire waveform_gen2_disable;
	wire waveform_gen1_disable;
	wire signal_modulator_disable;
	wire num_osc3_disable;
	wire num_osc2_disable;
	wire num_osc1_disable;

	assign waveform_gen3_disable    = waveform_value[6];
	assign waveform_gen2_disable    = waveform_value[5];
	assign waveform_gen1_disable    = waveform_value[4];
	assign signal_modulator_disable = waveform_value[3];
	assign num_osc3_disable         = waveform_value[2];
	assign num_osc2_disable         = waveform_value[1];
	assign num_osc1_disable         = waveform_value[0];

	// PWM and capture register: bits 7 and 3 have no peripheral behind them
	wire pwm_unit3_disable;
	wire pwm_unit2_disable;
	wire pwm_unit1_disable;
	wire capture_compare3_disable;
	wire capture_compare2_disable;
	wire capture_compare1_disable;

	assign pwm_unit3_disable        = pwm_capture_value[6];
	assign pwm_unit2_disable        = pwm_capture_value[5];
	assign pwm_unit1_disable        = pwm_capture_value[4];
	assign capture_compare3_disable = pwm_capture_value[2];
	assign capture_compare2_disable = pwm_capture_value[1];
	assign capture_compare1_disable = pwm_capture_value[0];

	// Serial register: UARTs 5..1 on top, then the two SPI units and I2C
	wire [5:1] uart_n_disable;
	wire       spi_unit2_disable;
	wire       spi_unit1_disable;
	wire       i2c_unit_disable;

	assign uart_n_disable    = serial_value[7:3];
	assign spi_unit2_disable = serial_value[2];
	assign spi_unit1_disable = serial_value[1];
	assign i2c_unit_disable  = serial_value[0];

	// One disable line per peripheral; bits 1..0 are spares that stay enabled
	wire [42:0] raw_disable;

	assign raw_disable = {
		uart_n_disable,              // 42..38
		spi_unit2_disable,           // 37
		spi_unit1_disable,           // 36
		i2c_unit_disable,            // 35
		pwm_unit3_disable,           // 34
		pwm_unit2_disable,           // 33
		pwm_unit1_disable,           // 32
		capture_compare3_disable,    // 31
		capture_compare2_disable,    // 30
		capture_compare1_disable,    // 29
		waveform_gen3_disable,       // 28
		waveform_gen2_disable,       // 27
		waveform_gen1_disable,       // 26
		signal_modulator_disable,    // 25
		num_osc3_disable,            // 24
		num_osc2_disable,            // 23
		num_osc1_disable,            // 22
		active_tuning_disable,       // 21
		dac_unit_disable,            // 20
		adc_unit_disable,            // 19
		comparator_two_disable,      // 18
		comparator_one_disable,      // 17
		zero_cross_disable,          // 16
		signal_meas_timer_disable,   // 15
		timer_n_disable,             // 14..8
		vref_disable,                // 7
		voltage_detect_disable,      // 6
		checksum_unit_disable,       // 5
		memory_scanner_disable,      // 4
		clock_ref_out_disable,       // 3
		pin_change_irq_disable,      // 2
		2'b00                        // 1..0
	};

	// Re-enable hold: block bus selects in the cycle of a clear and two more
	reg  [42:0] prev_disable_q;
	reg  [42:0] hold0_q;
	reg  [42:0] hold1_q;
	wire [42:0] reenabled;
	wire [42:0] sel_guard;

	assign reenabled = prev_disable_q & ~raw_disable;
	// Without the live term the select would open for one cycle at the clear
	assign sel_guard = reenabled | hold0_q | hold1_q;

	// [RULE7] Guard after re-enable
	always @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			prev_disable_q <= 43'h00000000000;
			hold0_q        <= 43'h00000000000;
			hold1_q        <= 43'h00000000000;
		end else begin
			prev_disable_q <= raw_disable;
			hold0_q        <= reenabled;
			hold1_q        <= hold0_q;
		end
	end

	// Per-peripheral control lines
	generate
		for (gi = 0; gi < `NUM_PERIPH; gi = gi + 1) begin : g_periph
			// [RULE3] Hold in reset
			// [RULE6] Release gives reset values
			assign PERIPH_RESET_HOLD[gi] = raw_disable[gi];
			// [RULE17] Clock gate per bit
			assign PERIPH_CLK_EN[gi] = ~raw_disable[gi] & ~periph_sysclk_gate;
			// [RULE5] Outputs forced inactive
			assign PERIPH_OUT_EN[gi] = ~raw_disable[gi];
			// [RULE4] Block register access
			assign PERIPH_REG_SEL[gi] = ~raw_disable[gi] & ~sel_guard[gi];
		end
	endgenerate

	// [RULE8] Gate system clock network
	assign PERIPH_SYSCLK_EN = OSC_CLK_EN & ~periph_sysclk_gate;
	// [RULE9] Quarter-rate clock ungated
	assign QUARTER_CLK_EN = OSC_CLK_EN;

endmodule

// ===== test/pmd_checker_properties.sv
// Port checker for the peripheral disable bank.
// Assumes binding onto the top module, whose port names it shares.
`timescale 1ns/1ps
module pmd_checker (
	input wire        CLK,
	input wire        NRST,
	input wire        AVS_READ,
	input wire        AVS_WRITE,
	input wire        AVS_WAITREQUEST,
	input wire [1:0]  AVS_RESPONSE,
	input wire        ZERO_CROSS_FUSE_ALLOW,
	input wire        OSC_CLK_EN,
	input wire        PERIPH_SYSCLK_EN,
	input wire        QUARTER_CLK_EN,
	input wire [42:0] PERIPH_RESET_HOLD,
	input wire [42:0] PERIPH_CLK_EN,
	input wire [42:0] PERIPH_OUT_EN,
	input wire [42:0] PERIPH_REG_SEL
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	reg  [42:0] hold_q;
	wire [42:0] fell = hold_q & ~PERIPH_RESET_HOLD;
	wire        req  = AVS_READ | AVS_WRITE;
	// Last hold state, to spot re-enables
	always @(posedge CLK or negedge NRST) begin
		if (!NRST)
			hold_q <= 43'h0;
		else
			hold_q <= PERIPH_RESET_HOLD;
	end
	a_one_wait: assert property (req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("bus answer late");
	a_resp_answer: assert property (AVS_RESPONSE != 2'h0 |-> req && !AVS_WAITREQUEST)
		else $error("response outside answer");
	a_out_gated: assert property (PERIPH_OUT_EN == ~PERIPH_RESET_HOLD)
		else $error("outputs not gated");
	a_clk_held: assert property ((PERIPH_CLK_EN & PERIPH_RESET_HOLD) == 43'h0)
		else $error("clock on while held");
	a_sys_gate: assert property (OSC_CLK_EN && !PERIPH_SYSCLK_EN |-> PERIPH_CLK_EN == 43'h0)
		else $error("clock not gated");
	a_quarter_free: assert property (QUARTER_CLK_EN == OSC_CLK_EN)
		else $error("quarter clock gated");
	a_sel_blocked: assert property ((PERIPH_REG_SEL & PERIPH_RESET_HOLD) == 43'h0)
		else $error("select while disabled");
	a_sel_guard: assert property (|fell |-> (PERIPH_REG_SEL & fell) == 43'h0 ##1
		(PERIPH_REG_SEL & $past(fell)) == 43'h0) else $error("select too early");
	a_fuse_block: assert property (!ZERO_CROSS_FUSE_ALLOW |-> !PERIPH_RESET_HOLD[16])
		else $error("zero-cross held without fuse");
	c_reenable: cover property (|fell);
	c_unmapped: cover property (AVS_RESPONSE == 2'h2);
	c_gated: cover property (OSC_CLK_EN && !PERIPH_SYSCLK_EN);
endmodule
bind peripheral_module_disable pmd_checker pmd_checker_inst (.*);

// ===== test/peripheral_module_disable_tb_top.sv
// Self-checking bench for the peripheral disable bank.
// Assumes the header constants and one wait state per access.
`timescale 1ns/1ps
`include "periph_disable_regs.vh"
module peripheral_module_disable_tb_top;
	reg         CLK = 1'b0;
	reg         NRST = 1'b0;
	reg  [13:0] AVS_ADDRESS = 14'h0;
	reg         AVS_READ = 1'b0;
	reg         AVS_WRITE = 1'b0;
	reg  [31:0] AVS_WRITEDATA = 32'h0;
	reg  [3:0]  AVS_BYTEENABLE = 4'hF;
	reg         ZERO_CROSS_FUSE_ALLOW = 1'b1;
	reg         OSC_CLK_EN = 1'b1;
	wire [31:0] AVS_READDATA;
	wire        AVS_WAITREQUEST;
	wire [1:0]  AVS_RESPONSE;
	wire        PERIPH_SYSCLK_EN;
	wire        QUARTER_CLK_EN;
	wire [42:0] PERIPH_RESET_HOLD;
	wire [42:0] PERIPH_CLK_EN;
	wire [42:0] PERIPH_OUT_EN;
	wire [42:0] PERIPH_REG_SEL;
	integer     errors = 0;
	integer     checked = 0;
	integer     i;
	integer     k;
	reg  [11:0] ix [0:5];
	reg  [7:0]  mk [0:5];
	reg  [7:0]  v [0:5];
	reg  [31:0] q;
	reg  [1:0]  r;
	peripheral_module_disable peripheral_module_disable_inst (.*);
	// Clock at 8 ns
	always #4 CLK = ~CLK;
	task finish_test;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input string nm, input [42:0] seen, input [42:0] exp);
		checked = checked + 1;
		if (seen !== exp) begin
			errors = errors + 1;
			$display("unexpected %0s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Request stays up until waitrequest is sampled low
	task acc(input w, input [11:0] a, input [7:0] d);
		integer n;
		AVS_ADDRESS <= {a, 2'b00};
		AVS_WRITE <= w;
		AVS_READ <= !w;
		AVS_WRITEDATA <= {24'h0, d};
		n = 0;
		@(posedge CLK);
		while (AVS_WAITREQUEST !== 1'b0 && n < 20) begin
			n = n + 1;
			@(posedge CLK);
		end
		if (n == 20) begin
			errors = errors + 1;
			finish_test;
		end
		q = AVS_READDATA;
		r = AVS_RESPONSE;
	endtask
	task idle;
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
		@(posedge CLK);
	endtask
	// Expected hold vector from written values
	function [42:0] hold(input f);
		hold = {v[5], v[4][6:4], v[4][2:0], v[3][6:0], v[2][7:5], v[2][2:1],
			v[2][0] & f, v[1], v[0][6:3], v[0][1:0], 2'b00};
	endfunction
	initial begin
		{ix[0], ix[1], ix[2], ix[3], ix[4], ix[5]} = {`IDX_DISABLE_SYS, `IDX_DISABLE_TIMERS,
			`IDX_DISABLE_ANALOG, `IDX_DISABLE_WAVEFORM, `IDX_DISABLE_PWM_CAPTURE,
			`IDX_DISABLE_SERIAL};
		{mk[0], mk[1], mk[2], mk[3], mk[4], mk[5]} = {`MASK_SYS, `MASK_TIMERS, `MASK_ANALOG,
			`MASK_WAVEFORM, `MASK_PWM_CAPTURE, `MASK_SERIAL};
		repeat (4) @(posedge CLK);
		NRST <= 1'b1;
		@(posedge CLK);
		for (i = 0; i < 6; i = i + 1) begin
			acc(0, ix[i], 8'h00);
			chk("reset", q, 43'h0);
		end
		idle;
		chk("hold0", PERIPH_RESET_HOLD, 43'h0);
		$display("reset test done");
		// every bit drives its own peripheral
		for (k = 0; k < 3; k = k + 1) begin
			ZERO_CROSS_FUSE_ALLOW <= (k != 1);
			for (i = 0; i < 6; i = i + 1) begin
				v[i] = (k == 0 ? 8'hFF : k == 1 ? 8'hA5 : 8'h5A) & mk[i];
				acc(1, ix[i], k == 0 ? 8'hFF : k == 1 ? 8'hA5 : 8'h5A);
			end
			for (i = 0; i < 6; i = i + 1) begin
				acc(0, ix[i], 8'h00);
				chk("data", q, v[i]);
			end
			idle;
			chk("hold", PERIPH_RESET_HOLD, hold(k != 1));
			chk("clk", PERIPH_CLK_EN, v[0][7] ? 43'h0 : ~hold(k != 1));
			chk("sysclk", PERIPH_SYSCLK_EN, !v[0][7]);
			chk("out", PERIPH_OUT_EN, ~hold(k != 1));
			chk("sel_on", PERIPH_REG_SEL, ~hold(k != 1));
		end
		$display("layout test done");
		for (i = 0; i < 6; i = i + 1)
			acc(1, ix[i], 8'h00);
		idle;
		chk("guard", PERIPH_REG_SEL[42:35], 8'hA5);
		repeat (3) @(posedge CLK);
		chk("sel", PERIPH_REG_SEL, ~43'h0);
		acc(1, 12'h062, 8'hFF);
		acc(0, 12'h062, 8'h00);
		chk("resp", r, 2'h2);
		chk("unmapped", q, 43'h0);
		idle;
		AVS_BYTEENABLE <= 4'hE;
		acc(1, ix[3], 8'hFF);
		idle;
		AVS_BYTEENABLE <= 4'hF;
		acc(0, ix[3], 8'h00);
		chk("byteen", q, 43'h0);
		acc(1, ix[0], 8'h80);
		idle;
		chk("quarter_on", QUARTER_CLK_EN, 43'h1);
		chk("gated", PERIPH_CLK_EN, 43'h0);
		OSC_CLK_EN <= 1'b0;
		@(posedge CLK);
		chk("quarter", QUARTER_CLK_EN, 43'h0);
		chk("sysoff", PERIPH_SYSCLK_EN, 43'h0);
		$display("access test done");
		NRST <= 1'b0;
		repeat (2) @(posedge CLK);
		NRST <= 1'b1;
		@(posedge CLK);
		acc(0, ix[0], 8'h00);
		chk("rereset", q, 43'h0);
		idle;
		$display("reset again test done");
		finish_test;
	end
endmodule
